/* File: hw/sfp_consts.vh */
// constants for the serial flash block protection logic
`ifndef SFP_CONSTS_VH
`define SFP_CONSTS_VH

// ****************************************
// command opcodes
// ****************************************
`define SFP_OP_WR_EN  8'h06
`define SFP_OP_WRDI   8'h04
`define SFP_OP_EQIO   8'h38
`define SFP_OP_RSTQIO 8'hff
`define SFP_OP_RDSR   8'h05
`define SFP_OP_RDCR   8'h35
`define SFP_OP_WRSR   8'h01
`define SFP_OP_WR_PROT 8'h42
`define SFP_OP_RBPR   8'h72
`define SFP_OP_ULBPR  8'h98
`define SFP_OP_LOCK   8'h8d
`define SFP_OP_WPWL   8'he8

// ****************************************
// frame lengths in bits, opcode included
// ****************************************
`define SFP_LEN_OP    7'd8
`define SFP_LEN_WRSR  7'd24
`define SFP_LEN_WPWL  7'd48
`define SFP_LEN_WRITE_PROTECTION_BITS_CMD  7'd56
`define SFP_LEN_CAP   7'd120

// ****************************************
// reset values and field positions
// ****************************************
`define SFP_PROT_RST   48'h5555_ffff_ffff
`define SFP_PROT_WMASK 48'h5555_ffff_ffff
`define SFP_PWL_RST   40'h00_0000_0000
`define SFP_SR_LATCH  1
`define SFP_SR_LOCK   4
`define SFP_CR_IOSEL  1
`define SFP_CR_PINEN  7

`endif

/* File: hw/sfp_protect.v */
// block protection, lock-down and write-protect pin logic of a serial flash
//
// Notes on behaviour
// - array split into eight 8K, two 32K, thirty 64K protection blocks
// - single-line mode after reset; quad only after mode-change command
// - mode 0 and 3 accepted; sample on rise, drive after fall
// - all blocks write-locked after every power-on reset
// - 48 protection bits: two per parameter block, one per overlay block
// - one means protected; parameter pair upper bit read-lock, lower write-lock
// - read of read-locked parameter block returns zero
// - global unlock clears every write-lock bit without a permanent lock in one command
// - lock command needs write enable; lock-down refuses protection changes
// - lock-down cleared only by power cycle, visible in status
// - 40 permanent write-lock bits, one per block, same mapping
// - permanent one forces matching write-lock to one, frozen forever
// - zero written to permanent bit changes nothing
// - lock-down makes device ignore permanent-lock writes
// - pin acts only in single-line mode with io config zero
// - pin ignored while pin-protect enable is zero
// - pin-protect enable nonvolatile, factory zero, kept across power-ups
// - pin guards only protection and config registers, not program/erase
// - config zero, enable one, pin low: block protection and config writes
// - lock-down rejects protection write; otherwise accepted if pin idle
// - status bit 4 set by lock command, cleared only by power cycle
// - write enable latch gates writes and clears after each such command
`timescale 1ns/1ps
`include "sfp_consts.vh"

module sfp_protect (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        nv_rst_n,
  input  wire        sck,
  input  wire        ce_n,
  input  wire [3:0]  quad_data_lines_i,
  input  wire        wp_n,
  output wire [3:0]  quad_data_lines_o,
  output wire [3:0]  quad_data_lines_oe_n,
  input  wire [23:0] arr_addr,
  input  wire [7:0]  arr_rdata,
  output reg  [7:0]  rd_data_q,
  output reg         blk_wr_ok_q,
  output wire        quad_mode,
  output wire        lockdown_status_flag,
  output wire        write_enable_latch
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg        sck_s1_q, sck_s2_q, sck_s3_q;
  reg        ce_s1_q,  ce_s2_q,  ce_s3_q;
  reg  [3:0] sio_s1_q, sio_s2_q;
  reg        wp_s1_q,  wp_s2_q;

  // two flops per pin; third flop only for edge finding
  always @(posedge core_clk) begin
    if (!rst_n) begin
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      ce_s1_q  <= 1'b1;
      ce_s2_q  <= 1'b1;
      ce_s3_q  <= 1'b1;
      sio_s1_q <= 4'h0;
      sio_s2_q <= 4'h0;
      wp_s1_q  <= 1'b1;
      wp_s2_q  <= 1'b1;
    end else begin
      sck_s1_q <= sck;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      ce_s1_q  <= ce_n;
      ce_s2_q  <= ce_s1_q;
      ce_s3_q  <= ce_s2_q;
      sio_s1_q <= quad_data_lines_i;
      sio_s2_q <= sio_s1_q;
      wp_s1_q  <= wp_n;
      wp_s2_q  <= wp_s1_q;
    end
  end

  // edge events; either idle level of sck is fine
  // both bus modes
  wire sck_rise = sck_s2_q & ~sck_s3_q;
  wire sck_fall = ~sck_s2_q & sck_s3_q;
  wire ce_fall  = ~ce_s2_q & ce_s3_q;
  wire ce_rise  = ce_s2_q & ~ce_s3_q;
  wire sel      = ~ce_s2_q;

  // ****************************************
  // state registers
  // ****************************************
  reg  [6:0]  bits_q;
  reg  [7:0]  op_q;
  reg  [47:0] din_q;
  reg  [47:0] dsh_q;
  reg         rd_act_q;
  reg  [3:0]  sio_o_q;
  reg  [3:0]  oe_n_q;
  reg         quad_q;
  reg         latch_q;
  reg         lock_q;
  reg  [47:0] prot_q;
  reg  [39:0] pwl_q;
  reg         iosel_q;
  reg         pinen_q;

  // widen 40 write-lock bits into the 48-bit protection layout
  // shared block mapping
  function [47:0] f_exp;
    input [39:0] v;
    integer i;
    begin
      f_exp = {16'h0000, v[31:0]};
      for (i = 0; i < 8; i = i + 1) begin
        f_exp[32 + 2 * i] = v[32 + i];
      end
    end
  endfunction

  // ****************************************
  // shift datapath
  // ****************************************
  wire [6:0]  step   = quad_q ? 7'd4 : 7'd1;
  wire [6:0]  bits_n = bits_q + step;
  wire [7:0]  op_n   = quad_q ? {op_q[3:0], sio_s2_q} : {op_q[6:0], sio_s2_q[0]};
  wire [47:0] din_n  = quad_q ? {din_q[43:0], sio_s2_q} : {din_q[46:0], sio_s2_q[0]};
  wire [47:0] pwl_x  = f_exp(pwl_q);

  // status and config images
  // lock-down readable
  wire [7:0] sr_img = (8'h01 << `SFP_SR_LOCK) & {8{lock_q}} |
                      (8'h01 << `SFP_SR_LATCH) & {8{latch_q}};
  wire [7:0] cr_img = (8'h01 << `SFP_CR_IOSEL) & {8{iosel_q}} |
                      (8'h01 << `SFP_CR_PINEN) & {8{pinen_q}};

  // read word chosen as soon as the opcode is complete
  reg        rd_sel;
  reg [47:0] rd_word;
  always @* begin
    rd_sel  = 1'b1;
    rd_word = 48'h0;
    case (op_n)
      `SFP_OP_RDSR: rd_word = {sr_img, 40'h0};
      `SFP_OP_RDCR: rd_word = {cr_img, 40'h0};
      `SFP_OP_RBPR: rd_word = prot_q;
      default:      rd_sel  = 1'b0;
    endcase
  end

  // ****************************************
  // command qualification at ce_n release
  // ****************************************
  wire end_op = ce_rise;
  wire len8   = (bits_q == `SFP_LEN_OP);

  // pin protection only in single-line mode, io config zero, enable set
  // io config priority
  wire pin_prot = ~quad_q & ~iosel_q & pinen_q & ~wp_s2_q;

  wire do_wprot = end_op & (op_q == `SFP_OP_WR_PROT) & (bits_q == `SFP_LEN_WRITE_PROTECTION_BITS_CMD) &
                  latch_q & ~lock_q & ~pin_prot;
  wire do_ulbpr = end_op & (op_q == `SFP_OP_ULBPR) & len8 &
                  latch_q & ~lock_q & ~pin_prot;
  wire do_lock  = end_op & (op_q == `SFP_OP_LOCK) & len8 & latch_q;
  wire do_wpwl  = end_op & (op_q == `SFP_OP_WPWL) & (bits_q == `SFP_LEN_WPWL) &
                  latch_q & ~lock_q;
  // config write blocked by pin too
  wire do_wrsr  = end_op & (op_q == `SFP_OP_WRSR) & (bits_q == `SFP_LEN_WRSR) &
                  latch_q & ~pin_prot;
  wire do_write_enable_cmd  = end_op & (op_q == `SFP_OP_WR_EN) & len8;

  // any write-type command drops the latch, accepted or not
  // latch auto-clear
  wire latch_clr = end_op & ((op_q == `SFP_OP_WRDI) | (op_q == `SFP_OP_WR_PROT) |
                   (op_q == `SFP_OP_ULBPR) | (op_q == `SFP_OP_LOCK) |
                   (op_q == `SFP_OP_WPWL) | (op_q == `SFP_OP_WRSR));

  // ****************************************
  // serial engine and volatile state
  // ****************************************
  always @(posedge core_clk) begin
    if (!rst_n) begin
      bits_q   <= 7'd0;
      op_q     <= 8'h00;
      din_q    <= 48'h0;
      dsh_q    <= 48'h0;
      rd_act_q <= 1'b0;
      sio_o_q  <= 4'h0;
      oe_n_q   <= 4'hf;
      quad_q   <= 1'b0;
      latch_q  <= 1'b0;
      lock_q   <= 1'b0;
      prot_q   <= `SFP_PROT_RST;
    end else begin
      // frame start clears the bit count
      if (ce_fall) begin
        bits_q   <= 7'd0;
        rd_act_q <= 1'b0;
      end else if (sel && sck_rise && bits_q < `SFP_LEN_CAP) begin
        bits_q <= bits_n;
        if (bits_q < `SFP_LEN_OP) begin
          op_q <= op_n;
        end else begin
          din_q <= din_n;
        end
        if (bits_n == `SFP_LEN_OP) begin
          rd_act_q <= rd_sel;
          dsh_q    <= rd_word;
        end
      end
      if (sel && sck_fall && rd_act_q) begin
        if (quad_q) begin
          sio_o_q <= dsh_q[47:44];
          oe_n_q  <= 4'h0;
          dsh_q   <= {dsh_q[43:0], 4'h0};
        end else begin
          sio_o_q <= {2'b00, dsh_q[47], 1'b0};
          oe_n_q  <= 4'hd;
          dsh_q   <= {dsh_q[46:0], 1'b0};
        end
      end
      // release lines when the frame ends
      if (ce_rise) begin
        oe_n_q   <= 4'hf;
        rd_act_q <= 1'b0;
      end
      if (end_op && len8 && op_q == `SFP_OP_EQIO) begin
        quad_q <= 1'b1;
      end else if (end_op && len8 && op_q == `SFP_OP_RSTQIO) begin
        quad_q <= 1'b0;
      end
      if (do_write_enable_cmd) begin
        latch_q <= 1'b1;
      end else if (latch_clr) begin
        latch_q <= 1'b0;
      end
      if (do_lock) begin
        lock_q <= 1'b1;
      end
      if (do_wprot) begin
        prot_q <= din_q | pwl_x;
      end else if (do_ulbpr) begin
        prot_q <= (prot_q & ~`SFP_PROT_WMASK) | pwl_x;
      end else if (do_wpwl) begin
        prot_q <= prot_q | f_exp(din_q[39:0]);
      end
    end
  end

  // ****************************************
  // nonvolatile state, kept over rst_n
  // ****************************************
  // nv_rst_n stands for the factory state, not a power cycle
  always @(posedge core_clk) begin
    if (!nv_rst_n) begin
      pwl_q  <= `SFP_PWL_RST;
      iosel_q <= 1'b0;
      pinen_q <= 1'b0;
    end else begin
      if (do_wpwl) begin
        pwl_q <= pwl_q | din_q[39:0];
      end
      if (do_wrsr) begin
        iosel_q <= din_q[`SFP_CR_IOSEL];
        pinen_q <= din_q[`SFP_CR_PINEN];
      end
    end
  end

  // ****************************************
  // array access gating
  // ****************************************
  // 8K units: 4 params, 32K, 64K x30, 32K, 4 params
  // block decode
  wire [7:0] unit   = arr_addr[20:13];
  wire       is_par = (unit < 8'd4) | (unit > 8'd251);
  wire [2:0] pidx   = {~(unit < 8'd4), unit[1:0]};
  wire [4:0] oidx   = unit[7:3];

  // upper bit read, lower bit write
  wire rlock = is_par & prot_q[{2'b10, pidx, 1'b1}];
  wire wlock = is_par ? prot_q[{2'b10, pidx, 1'b0}] : prot_q[{1'b0, oidx}];

  // pin does not enter this path
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data_q   <= 8'h00;
      blk_wr_ok_q <= 1'b0;
    end else begin
      rd_data_q   <= rlock ? 8'h00 : arr_rdata;
      blk_wr_ok_q <= latch_q & ~wlock;
    end
  end

  assign quad_data_lines_o    = sio_o_q;
  assign quad_data_lines_oe_n = oe_n_q;
  assign quad_mode            = quad_q;
  assign lockdown_status_flag = lock_q;
  assign write_enable_latch   = latch_q;

endmodule // sfp_protect

/* File: testbench/sfp_protect_chk.sv */
// assertion checker for the protection block ports
`timescale 1ns/1ps
module sfp_protect_chk (
  input wire       core_clk,
  input wire       rst_n,
  input wire       sck,
  input wire       ce_n,
  input wire [7:0] arr_rdata,
  input wire [7:0] rd_data_q,
  input wire       blk_wr_ok_q,
  input wire       quad_mode,
  input wire       lockdown_status_flag,
  input wire       write_enable_latch,
  input wire [3:0] quad_data_lines_o,
  input wire [3:0] quad_data_lines_oe_n
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // selected with clock high, so no fall is pending
  sequence s_hi_sel;
    (sck && !ce_n)[*8];
  endsequence
  // deselected long enough for the release to land
  sequence s_desel;
    ce_n[*8];
  endsequence
  a_reset_state: assert property (
    rst_n && !$past(rst_n) |-> !quad_mode && !lockdown_status_flag && !write_enable_latch
    && !blk_wr_ok_q && quad_data_lines_oe_n == 4'hf) else $error("bad state after reset");
  a_lock_holds: assert property (
    lockdown_status_flag |=> lockdown_status_flag) else $error("lock flag dropped");
  a_read_zero: assert property (
    rd_data_q != 8'h00 |-> rd_data_q == $past(arr_rdata)) else $error("read byte wrong");
  a_ok_needs_wel: assert property (
    blk_wr_ok_q |-> $past(write_enable_latch)) else $error("write ok without latch");
  a_lock_drops_wel: assert property (
    $rose(lockdown_status_flag) |-> ##[0:2] !write_enable_latch) else $error("latch kept");
  a_lock_idle: assert property (
    $rose(lockdown_status_flag) |-> ce_n) else $error("lock set inside frame");
  a_mode_idle: assert property (
    $changed(quad_mode) |-> ce_n) else $error("mode changed inside frame");
  a_quad_oe: assert property (
    quad_data_lines_oe_n == 4'h0 |-> quad_mode) else $error("four lines in single mode");
  a_out_on_fall: assert property (
    s_hi_sel |=> $stable(quad_data_lines_o)) else $error("output moved, clock high");
  a_oe_release: assert property (
    s_desel |-> quad_data_lines_oe_n == 4'hf) else $error("driven while deselected");
endmodule // sfp_protect_chk
bind sfp_protect sfp_protect_chk i_chk (
  .core_clk(core_clk), .rst_n(rst_n), .sck(sck), .ce_n(ce_n), .arr_rdata(arr_rdata),
  .rd_data_q(rd_data_q), .blk_wr_ok_q(blk_wr_ok_q), .quad_mode(quad_mode),
  .lockdown_status_flag(lockdown_status_flag), .write_enable_latch(write_enable_latch),
  .quad_data_lines_o(quad_data_lines_o), .quad_data_lines_oe_n(quad_data_lines_oe_n));

/* File: testbench/sfp_host.sv */
// host serial controller model driving the flash link
`timescale 1ns/1ps
module sfp_host (
  input  wire logic       core_clk,
  input  wire logic [3:0] dq,
  output logic            sck,
  output logic            ce_n,
  output logic [3:0]      sio
);
  logic cpol = 1'b0;
  logic quad = 1'b0;
  initial begin
    sck = 1'b0;
    ce_n = 1'b1;
    sio = 4'h0;
  end
  // step on the core clock, always just after its edge
  task automatic hp(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // drive while low, device samples on rise; idle level follows cpol
  task automatic xfer(input logic [63:0] tx, input int nb, output logic [63:0] rx);
    int w;
    w = quad ? 4 : 1;
    rx = '0;
    ce_n = 1'b0;
    hp(4);
    for (int i = nb - w; i >= 0; i -= w) begin
      sck = 1'b0;
      sio = quad ? tx[i+:4] : {~sio[3:1], tx[i]}; // unused lines keep toggling
      hp(16);
      sck = 1'b1;
      rx = quad ? {rx[59:0], dq} : {rx[62:0], dq[1]};
      hp(16);
    end
    sck = cpol;
    hp(2);
    ce_n = 1'b1;
    sio = ~sio; // released lines must not hold the last value
    hp(40);
  endtask
endmodule // sfp_host

/* File: testbench/testbench.sv */
// self-checking bench for the block protection logic
`timescale 1ns/1ps
`include "sfp_consts.vh"
module testbench;
  logic        core_clk  = 1'b0;
  logic        rst_n     = 1'b0;
  logic        nv_rst_n  = 1'b0;
  logic        wp_n      = 1'b1;
  logic [23:0] arr_addr  = 24'h000000;
  logic [7:0]  arr_rdata = 8'ha5;
  wire         sck, ce_n, quad_mode, lock, latch, blk_ok;
  wire  [3:0]  sio_h, dq_o, dq_oe_n, dq;
  wire  [7:0]  rd_q;
  int          mismatches = 0;
  int          compares   = 0;
  int          cyc        = 0;
  // ****************************************
  // clock, wire level, instances
  // ****************************************
  always #2.5 core_clk = ~core_clk;
  assign dq = (sio_h & dq_oe_n) | (dq_o & ~dq_oe_n); // device wins where enabled
  sfp_protect i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .nv_rst_n(nv_rst_n), .sck(sck), .ce_n(ce_n),
    .quad_data_lines_i(dq), .wp_n(wp_n), .quad_data_lines_o(dq_o),
    .quad_data_lines_oe_n(dq_oe_n), .arr_addr(arr_addr), .arr_rdata(arr_rdata),
    .rd_data_q(rd_q), .blk_wr_ok_q(blk_ok), .quad_mode(quad_mode),
    .lockdown_status_flag(lock), .write_enable_latch(latch));
  sfp_host h (.core_clk(core_clk), .dq(dq), .sck(sck), .ce_n(ce_n), .sio(sio_h));
  // ****************************************
  // tasks
  // ****************************************
  task automatic ck(input string n, input logic [47:0] e, input logic [47:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] op, input logic [47:0] d, input int nb);
    logic [63:0] r;
    h.xfer(({56'h0, op} << nb) | {16'h0, d}, nb + 8, r);
  endtask
  task automatic we(input logic [7:0] op, input logic [47:0] d, input int nb);
    wr(`SFP_OP_WR_EN, 48'h0, 0);
    wr(op, d, nb);
  endtask
  task automatic rd(input logic [7:0] op, input int nb, input string n, input logic [47:0] e);
    logic [63:0] r;
    h.xfer({56'h0, op} << nb, nb + 8, r);
    ck(n, e, r[47:0] & ((48'h1 << nb) - 48'h1));
  endtask
  // array port answers one edge after the address
  task automatic arr(input logic [23:0] a, input logic [7:0] ed, input logic eo);
    @(posedge core_clk);
    #1 arr_addr = a;
    @(posedge core_clk);
    #1;
    ck("rd_data_q", {40'h0, ed}, {40'h0, rd_q});
    ck("blk_wr_ok_q", {47'h0, eo}, {47'h0, blk_ok});
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      print_verdict;
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (8) @(posedge core_clk);
    #1 rst_n = 1'b1;
    nv_rst_n = 1'b1;
    h.hp(4);
    rd(`SFP_OP_RBPR, 48, "block_protection_bits", 48'h5555_ffff_ffff);
    wr(`SFP_OP_WR_PROT, 48'h0, 48);
    rd(`SFP_OP_RBPR, 48, "block_protection_bits", 48'h5555_ffff_ffff);
    wr(`SFP_OP_WR_EN, 48'h0, 0);
    rd(`SFP_OP_RDSR, 8, "status", 48'h02);
    $display("test latch done");
    wp_n = 1'b0;
    we(`SFP_OP_WRSR, 48'h0082, 16);
    rd(`SFP_OP_RDCR, 8, "config", 48'h82);
    we(`SFP_OP_WR_PROT, 48'hff, 48);
    rd(`SFP_OP_RBPR, 48, "block_protection_bits", 48'hff);
    we(`SFP_OP_WRSR, 48'h0080, 16);
    we(`SFP_OP_WR_PROT, 48'h0, 48);
    we(`SFP_OP_WRSR, 48'h0000, 16);
    rd(`SFP_OP_RBPR, 48, "block_protection_bits", 48'hff);
    rd(`SFP_OP_RDCR, 8, "config", 48'h80);
    wp_n = 1'b1;
    we(`SFP_OP_WRSR, 48'h0000, 16);
    wp_n = 1'b0;
    we(`SFP_OP_WR_PROT, 48'h0003_0000_0f00, 48);
    rd(`SFP_OP_RBPR, 48, "block_protection_bits", 48'h0003_0000_0f00);
    $display("test pin done");
    arr(24'h000000, 8'h00, 1'b0);
    arr(24'h1fe000, 8'ha5, 1'b0);
    we(`SFP_OP_WPWL, 48'h04, 40);
    rd(`SFP_OP_RBPR, 48, "block_protection_bits", 48'h0003_0000_0f04);
    we(`SFP_OP_ULBPR, 48'h0, 0);
    rd(`SFP_OP_RBPR, 48, "block_protection_bits", 48'h0002_0000_0004);
    we(`SFP_OP_WPWL, 48'h0, 40);
    we(`SFP_OP_WR_PROT, 48'h0, 48);
    rd(`SFP_OP_RBPR, 48, "block_protection_bits", 48'h0000_0000_0004);
    wr(`SFP_OP_WR_EN, 48'h0, 0);
    arr(24'h020000, 8'ha5, 1'b0);
    arr(24'h030000, 8'ha5, 1'b1);
    $display("test perm done");
    h.cpol = 1'b1;
    // latch is still set from above; drop it so the lock attempt is truly refused
    wr(`SFP_OP_WRDI, 48'h0, 0);
    ck("write_enable_latch", 48'h0, {47'h0, latch});
    wr(`SFP_OP_LOCK, 48'h0, 0);
    rd(`SFP_OP_RDSR, 8, "status", 48'h00);
    we(`SFP_OP_LOCK, 48'h0, 0);
    ck("lockdown_status_flag", 48'h1, {47'h0, lock});
    rd(`SFP_OP_RDSR, 8, "status", 48'h10);
    we(`SFP_OP_WR_PROT, 48'hffff_ffff_ffff, 48);
    we(`SFP_OP_WPWL, 48'h80_0000_0000, 40);
    we(`SFP_OP_ULBPR, 48'h0, 0);
    rd(`SFP_OP_RBPR, 48, "block_protection_bits", 48'h0000_0000_0004);
    rst_n = 1'b0;
    h.hp(4);
    rst_n = 1'b1;
    h.hp(4);
    rd(`SFP_OP_RDSR, 8, "status", 48'h00);
    rd(`SFP_OP_RBPR, 48, "block_protection_bits", 48'h5555_ffff_ffff);
    we(`SFP_OP_ULBPR, 48'h0, 0);
    rd(`SFP_OP_RBPR, 48, "block_protection_bits", 48'h0000_0000_0004);
    $display("test lock done");
    h.cpol = 1'b0;
    wr(`SFP_OP_EQIO, 48'h0, 0);
    ck("quad_mode", 48'h1, {47'h0, quad_mode});
    h.quad = 1'b1;
    // set the latch so the quad read carries a nonzero nibble the host cannot fake
    wr(`SFP_OP_WR_EN, 48'h0, 0);
    rd(`SFP_OP_RDSR, 8, "status", 48'h02);
    wr(`SFP_OP_RSTQIO, 48'h0, 0);
    h.quad = 1'b0;
    ck("quad_mode", 48'h0, {47'h0, quad_mode});
    $display("test mode done");
    print_verdict;
  end
endmodule // testbench
